// [design/dscc_cfg.svh]
/*
 Constants for the dual source charger control: register offsets,
 field positions, reset values, slave addresses and timer counts.
 Assumes a 25 MHz mclk.
*/
`ifndef DSCC_CFG_SVH
`define DSCC_CFG_SVH
`define DSCC_ADDR_USB 7'h6b
`define DSCC_ADDR_WALL 7'h6a
`define DSCC_OFS_STATUS 3'h0
`define DSCC_OFS_LIMIT 3'h1
`define DSCC_OFS_FLOAT 3'h2
`define DSCC_OFS_CURRENT 3'h4
`define DSCC_OFS_SPECIAL 3'h5
`define DSCC_BIT_KICK 1
`define DSCC_BIT_HIZ 1
`define DSCC_BIT_CDIS 2
`define DSCC_BIT_TE 3
`define DSCC_FAULT_TIMER 3'h6
`define DSCC_RST_STATUS 8'h00
`define DSCC_RST_LIMIT 8'h08
`define DSCC_RST_FLOAT 8'h08
`define DSCC_RST_CURRENT 8'h01
`define DSCC_RST_SPECIAL 8'h01
`define DSCC_CLK_HZ 25000000
`define DSCC_T15_S 900
`define DSCC_T32_S 32
`define DSCC_T15_CYC (36'(`DSCC_T15_S) * 36'(`DSCC_CLK_HZ))
`define DSCC_T32_CYC (36'(`DSCC_T32_S) * 36'(`DSCC_CLK_HZ))
`define DSCC_FLOAT_MAX 6'h2f
`define DSCC_FLOAT_BASE_MV 3500
`define DSCC_FLOAT_STEP_MV 20
`endif

// [design/dscc_float_dec.sv]
/*
 Float-voltage code to millivolt decoder.
 Assumes a pure combinational use.
*/
`timescale 1ns/1ps
`include "dscc_cfg.svh"
module dscc_float_dec (
    // Code in
    input wire logic [5:0] float_voltage_code,
    // Millivolts out
    output logic [12:0] float_mv
);
    logic [5:0] code_sat;
    // Saturate at the top code, then scale
    always_comb begin
        code_sat = (float_voltage_code > `DSCC_FLOAT_MAX) ?
            `DSCC_FLOAT_MAX : float_voltage_code;
        float_mv = 13'(`DSCC_FLOAT_BASE_MV) +
            13'(code_sat) * 13'(`DSCC_FLOAT_STEP_MV);
    end
endmodule : dscc_float_dec

// [design/dscc_i2c_slave.sv]
/*
 Two-wire serial slave answering two addresses, byte wide registers.
 Assumes scl and sda_in already pass two flip-flops in the caller.
*/
`timescale 1ns/1ps
module dscc_i2c_slave (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Synchronised bus levels
    input wire logic scl,
    input wire logic sda,
    output logic sda_oe,
    // Register access
    output logic wr_stb,
    output logic wr_bank,
    output logic [2:0] wr_ofs,
    output logic [7:0] wr_data,
    output logic [2:0] rd_ofs,
    output logic rd_bank,
    input wire logic [7:0] rd_data
);
    typedef enum logic [2:0] {
        S_IDLE, S_ADDR, S_ACK, S_WDATA, S_RDATA, S_RACK
    } dscc_i2c_st_type;
    dscc_i2c_st_type st_ff;
    logic scl_d_ff, sda_d_ff;
    logic [3:0] bit_ff;
    logic [7:0] sh_ff;
    logic rw_ff, have_ofs_ff, bank_ff, ack_ff;
    logic [2:0] ofs_ff;
    logic scl_rise, scl_fall, start_c, stop_c;
    // Bus edge and condition detect
    assign scl_rise = scl & ~scl_d_ff;
    assign scl_fall = ~scl & scl_d_ff;
    assign start_c = scl & scl_d_ff & sda_d_ff & ~sda;
    assign stop_c = scl & scl_d_ff & ~sda_d_ff & sda;
    assign rd_ofs = ofs_ff;
    assign rd_bank = bank_ff;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_d_ff <= 1'b1;
            sda_d_ff <= 1'b1;
        end else begin
            scl_d_ff <= scl;
            sda_d_ff <= sda;
        end
    end
    // Byte engine
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_ff <= S_IDLE;
            bit_ff <= 4'h0;
            sh_ff <= 8'h00;
            rw_ff <= 1'b0;
            have_ofs_ff <= 1'b0;
            bank_ff <= 1'b0;
            ack_ff <= 1'b0;
            ofs_ff <= 3'h0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_bank <= 1'b0;
            wr_ofs <= 3'h0;
            wr_data <= 8'h00;
        end else begin
            wr_stb <= 1'b0;
            if (start_c) begin
                st_ff <= S_ADDR;
                bit_ff <= 4'h0;
                have_ofs_ff <= 1'b0;
                sda_oe <= 1'b0;
            end else if (stop_c) begin
                st_ff <= S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                unique case (st_ff)
                    S_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    S_ADDR, S_WDATA: begin
                        if (scl_rise) begin
                            sh_ff <= {sh_ff[6:0], sda};
                            bit_ff <= bit_ff + 4'h1;
                        end
                        if (scl_fall && bit_ff == 4'h8) begin
                            bit_ff <= 4'h0;
                            ack_ff <= 1'b0;
                            if (st_ff == S_ADDR) begin
                                // Two addresses, one per input bank
                                if (sh_ff[7:1] == `DSCC_ADDR_USB ||
                                    sh_ff[7:1] == `DSCC_ADDR_WALL) begin
                                    bank_ff <= (sh_ff[7:1] ==
                                        `DSCC_ADDR_WALL);
                                    rw_ff <= sh_ff[0];
                                    sda_oe <= 1'b1;
                                    st_ff <= S_ACK;
                                end else begin
                                    st_ff <= S_IDLE;
                                end
                            end else begin
                                sda_oe <= 1'b1;
                                st_ff <= S_ACK;
                                if (!have_ofs_ff) begin
                                    ofs_ff <= sh_ff[2:0];
                                    have_ofs_ff <= 1'b1;
                                end else begin
                                    // Byte write to the chosen bank
                                    wr_stb <= 1'b1;
                                    wr_bank <= bank_ff;
                                    wr_ofs <= ofs_ff;
                                    wr_data <= sh_ff;
                                    ofs_ff <= ofs_ff + 3'h1;
                                end
                            end
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            if (rw_ff) begin
                                sh_ff <= rd_data;
                                sda_oe <= ~rd_data[7];
                                st_ff <= S_RDATA;
                            end else begin
                                sda_oe <= 1'b0;
                                st_ff <= S_WDATA;
                            end
                        end
                    end
                    S_RDATA: begin
                        if (scl_fall) begin
                            if (bit_ff == 4'h7) begin
                                bit_ff <= 4'h0;
                                sda_oe <= 1'b0;
                                ofs_ff <= ofs_ff + 3'h1;
                                st_ff <= S_RACK;
                            end else begin
                                bit_ff <= bit_ff + 4'h1;
                                sh_ff <= {sh_ff[6:0], 1'b0};
                                sda_oe <= ~sh_ff[6];
                            end
                        end
                    end
                    S_RACK: begin
                        if (scl_rise) begin
                            ack_ff <= ~sda;
                        end
                        if (scl_fall) begin
                            st_ff <= ack_ff ? S_ACK : S_IDLE;
                        end
                    end
                    default: begin
                        st_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule : dscc_i2c_slave

// [design/dscc_pkg.sv]
/*
 Types of the dual source charger control.
 Assumes dscc_cfg.svh is available on the include path.
*/
package dscc_pkg;
    // Which input charges the battery
    typedef enum logic [1:0] {
        DSCC_SRC_NONE,
        DSCC_SRC_USB,
        DSCC_SRC_WALL
    } dscc_src_type;

    // One register bank
    typedef struct packed {
        logic [7:0] status;
        logic [7:0] limit;
        logic [7:0] float_v;
        logic [7:0] current;
        logic [7:0] special;
    } dscc_bank_type;

    // Analog-side sense levels
    typedef struct packed {
        logic wall_valid;
        logic usb_valid;
        logic batt_weak;
        logic batt_short;
        logic term_reached;
        logic fault_event;
        logic [2:0] fault_code;
    } dscc_sense_type;

    // Analog-side controls
    typedef struct packed {
        logic charge_on;
        logic from_wall;
        logic precharge;
        logic boost_on;
        logic floor_loop_on;
        logic block_path;
        logic [5:0] float_voltage_code;
        logic [3:0] charge_current_code;
        logic [1:0] usb_input_current_limit;
        logic [2:0] termination_current_code;
        logic [2:0] input_voltage_floor_code;
    } dscc_ctrl_type;
endpackage : dscc_pkg

// [design/dscc_top.sv]
/*
 Dual source charger control: source choice, two register banks,
 unattended and watchdog timers, fault routing, analog controls.
 Assumes sense levels are mclk-synchronous; scl and sda are pins.
*/
`timescale 1ns/1ps
`include "dscc_cfg.svh"
module dscc_top #(
    parameter logic [35:0] T15_CYC = 36'(`DSCC_T15_CYC),
    parameter logic [35:0] T32_CYC = 36'(`DSCC_T32_CYC)
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Serial bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Analog interface
    input wire dscc_pkg::dscc_sense_type sense,
    input wire logic boost_req,
    output dscc_pkg::dscc_ctrl_type ctrl,
    output logic [12:0] float_mv,
    output dscc_pkg::dscc_src_type selected_charge_input
);
    import dscc_pkg::*;
    dscc_bank_type bank_ff [2];
    dscc_src_type src_ff, nxt_src;
    logic [1:0] scl_s_ff, sda_s_ff;
    logic wr_stb, wr_bank, rd_bank;
    logic [2:0] wr_ofs, rd_ofs;
    logic [7:0] wr_data, rd_data;
    logic [35:0] t15_ff, t32_ff;
    logic attended_ff, done_ff, both_gone_ff, charging;
    logic wall_prev_ff, usb_prev_ff, t15_exp, t32_exp, act;
    dscc_bank_type ab;

    // Pins into mclk domain
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_s_ff <= 2'h3;
            sda_s_ff <= 2'h3;
        end else begin
            scl_s_ff <= {scl_s_ff[0], scl_in};
            sda_s_ff <= {sda_s_ff[0], sda_in};
        end
    end
    assign sda_out = 1'b0;

    dscc_i2c_slave u_slave (
        .mclk(mclk),
        .reset_n(reset_n),
        .scl(scl_s_ff[1]),
        .sda(sda_s_ff[1]),
        .sda_oe(sda_oe),
        .wr_stb(wr_stb),
        .wr_bank(wr_bank),
        .wr_ofs(wr_ofs),
        .wr_data(wr_data),
        .rd_ofs(rd_ofs),
        .rd_bank(rd_bank),
        .rd_data(rd_data)
    );

    // Read mux, unmapped offsets read zero
    always_comb begin
        unique case (rd_ofs)
            `DSCC_OFS_STATUS: rd_data = bank_ff[rd_bank].status;
            `DSCC_OFS_LIMIT: rd_data = bank_ff[rd_bank].limit;
            `DSCC_OFS_FLOAT: rd_data = bank_ff[rd_bank].float_v;
            `DSCC_OFS_CURRENT: rd_data = bank_ff[rd_bank].current;
            `DSCC_OFS_SPECIAL: rd_data = bank_ff[rd_bank].special;
            default: rd_data = 8'h00;
        endcase
    end

    // Source selection, wall preferred
    always_comb begin
        if (sense.wall_valid) begin
            nxt_src = DSCC_SRC_WALL;
        end else if (sense.usb_valid) begin
            nxt_src = DSCC_SRC_USB;
        end else begin
            nxt_src = DSCC_SRC_NONE;
        end
    end
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            src_ff <= DSCC_SRC_NONE;
        end else begin
            src_ff <= nxt_src;
        end
    end
    assign selected_charge_input = src_ff;
    assign act = (src_ff == DSCC_SRC_WALL);
    assign ab = bank_ff[act];

    // Input history for weak battery restart
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wall_prev_ff <= 1'b0;
            usb_prev_ff <= 1'b0;
            both_gone_ff <= 1'b1;
        end else begin
            wall_prev_ff <= sense.wall_valid;
            usb_prev_ff <= sense.usb_valid;
            if (!sense.wall_valid && !sense.usb_valid) begin
                both_gone_ff <= 1'b1;
            end else if (both_gone_ff) begin
                both_gone_ff <= 1'b0;
            end
        end
    end

    // Timers: unattended until a write, then host watchdog
    assign t15_exp = !attended_ff && charging && t15_ff == T15_CYC - 36'h1;
    assign t32_exp = attended_ff && t32_ff == T32_CYC - 36'h1;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            t15_ff <= 36'h0;
            t32_ff <= 36'h0;
            attended_ff <= 1'b0;
        end else begin
            if (t32_exp) begin
                attended_ff <= 1'b0;
                t32_ff <= 36'h0;
                t15_ff <= 36'h0;
            end else if (wr_stb) begin
                attended_ff <= 1'b1;
                if (wr_ofs == `DSCC_OFS_STATUS &&
                    wr_data[`DSCC_BIT_KICK]) begin
                    t32_ff <= 36'h0;
                end
            end else if (attended_ff) begin
                t32_ff <= t32_ff + 36'h1;
            end else if (t15_exp) begin
                // Expiry restarts the count for the next charge
                t15_ff <= 36'h0;
            end else if (charging) begin
                t15_ff <= t15_ff + 36'h1;
            end
            if (both_gone_ff) begin
                t15_ff <= 36'h0;
            end
        end
    end

    // Register banks, host writes and hardware events
    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge mclk or negedge reset_n) begin
            if (!reset_n) begin
                bank_ff[b] <= {`DSCC_RST_STATUS, `DSCC_RST_LIMIT,
                    `DSCC_RST_FLOAT, `DSCC_RST_CURRENT, `DSCC_RST_SPECIAL};
            end else begin
                if (wr_stb && wr_bank == 1'(b)) begin
                    unique case (wr_ofs)
                        `DSCC_OFS_STATUS:
                            bank_ff[b].status[7:3] <= wr_data[7:3];
                        `DSCC_OFS_LIMIT: bank_ff[b].limit <= wr_data;
                        `DSCC_OFS_FLOAT: bank_ff[b].float_v <= wr_data;
                        `DSCC_OFS_CURRENT: bank_ff[b].current <= wr_data;
                        `DSCC_OFS_SPECIAL: bank_ff[b].special <= wr_data;
                        default: ;
                    endcase
                end
                // Watchdog resets only the active bank
                if (t32_exp && act == 1'(b)) begin
                    bank_ff[b] <= {5'h00, `DSCC_FAULT_TIMER,
                        `DSCC_RST_LIMIT, `DSCC_RST_FLOAT,
                        `DSCC_RST_CURRENT, `DSCC_RST_SPECIAL};
                end
                // Fault only into the charging input's status
                if (sense.fault_event && charging && act == 1'(b)) begin
                    bank_ff[b].status[2:0] <= sense.fault_code;
                end
                // Unattended expiry: disable the active bank and, while done_ff is clear, any bank whose input is present
                if (t15_exp) begin
                    if (attended_ff == 1'b0 && act == 1'(b)) begin
                        bank_ff[b].status[2:0] <= `DSCC_FAULT_TIMER;
                        bank_ff[b].limit[`DSCC_BIT_CDIS] <= 1'b1;
                    end
                    if (b == 1 ? sense.wall_valid && !done_ff
                               : sense.usb_valid && !done_ff) begin
                        bank_ff[b].limit[`DSCC_BIT_CDIS] <= 1'b1;
                    end
                end
                // Restart after both inputs removed clears disable
                if (both_gone_ff && sense.batt_weak &&
                    (sense.wall_valid || sense.usb_valid)) begin
                    bank_ff[b].limit[`DSCC_BIT_CDIS] <= 1'b0;
                end
            end
        end
    end

    // Done flag: watchdog event narrows later disables to active bank
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            done_ff <= 1'b0;
        end else if (t32_exp) begin
            done_ff <= 1'b1;
        end else if (both_gone_ff) begin
            done_ff <= 1'b0;
        end
    end

    // Charge control
    always_comb begin
        charging = src_ff != DSCC_SRC_NONE &&
            !ab.limit[`DSCC_BIT_CDIS] && !ab.special[`DSCC_BIT_HIZ] &&
            !(sense.term_reached && ab.limit[`DSCC_BIT_TE]);
        // High impedance in the active bank, wall or USB, blocks charge and path
        ctrl.charge_on = charging;
        ctrl.from_wall = act;
        ctrl.precharge = charging && sense.batt_short;
        ctrl.block_path = src_ff == DSCC_SRC_NONE ||
            ab.special[`DSCC_BIT_HIZ];
        ctrl.boost_on = boost_req && !ab.special[`DSCC_BIT_HIZ] &&
            (!charging || act);
        ctrl.floor_loop_on = charging;
        ctrl.float_voltage_code = ab.float_v[7:2];
        ctrl.charge_current_code = act ? ab.current[6:3] :
            {1'b0, ab.current[6:4]};
        ctrl.usb_input_current_limit = bank_ff[0].limit[7:6];
        ctrl.termination_current_code = ab.current[2:0];
        ctrl.input_voltage_floor_code = ab.special[2:0];
    end

    dscc_float_dec u_float (
        .float_voltage_code(ctrl.float_voltage_code),
        .float_mv(float_mv)
    );

    // Checks
    property p_wall_pref;
        @(posedge mclk) disable iff (!reset_n)
        sense.wall_valid |=> src_ff == DSCC_SRC_WALL;
    endproperty
    a_wall_pref: assert property (p_wall_pref)
        else $error("wall not chosen");
    property p_hiz_off;
        @(posedge mclk) disable iff (!reset_n)
        ab.special[`DSCC_BIT_HIZ] |-> !ctrl.charge_on && !ctrl.boost_on;
    endproperty
    a_hiz_off: assert property (p_hiz_off)
        else $error("hiz leaves power on");
    property p_boost;
        @(posedge mclk) disable iff (!reset_n)
        ctrl.boost_on && ctrl.charge_on |-> ctrl.from_wall;
    endproperty
    a_boost: assert property (p_boost)
        else $error("boost with usb charge");
    property p_wdog;
        @(posedge mclk) disable iff (!reset_n)
        t32_exp |=> ab.status[2:0] == `DSCC_FAULT_TIMER && !attended_ff;
    endproperty
    a_wdog: assert property (p_wdog)
        else $error("watchdog fault missing");
    property p_t15;
        @(posedge mclk) disable iff (!reset_n)
        t15_exp |=> ab.limit[`DSCC_BIT_CDIS] && !ctrl.charge_on;
    endproperty
    a_t15: assert property (p_t15)
        else $error("timer expiry left charge on");
    property p_term;
        @(posedge mclk) disable iff (!reset_n)
        sense.term_reached && ab.limit[`DSCC_BIT_TE] |-> !ctrl.charge_on;
    endproperty
    a_term: assert property (p_term)
        else $error("no termination");
    property p_pre;
        @(posedge mclk) disable iff (!reset_n)
        ctrl.precharge |-> sense.batt_short && ctrl.charge_on;
    endproperty
    a_pre: assert property (p_pre)
        else $error("bad precharge");
    property p_float;
        @(posedge mclk) disable iff (!reset_n)
        ctrl.float_voltage_code >= 6'h2f |-> float_mv == 13'h1158;
    endproperty
    a_float: assert property (p_float)
        else $error("float not saturated");
    c_wdog: cover property (@(posedge mclk) disable iff (!reset_n) t32_exp);
    c_t15: cover property (@(posedge mclk) disable iff (!reset_n) t15_exp);
    c_hand: cover property (@(posedge mclk) disable iff (!reset_n)
        src_ff == DSCC_SRC_USB ##1 src_ff == DSCC_SRC_WALL);
endmodule : dscc_top

// [verification/dscc_host_model.sv]
/*
 Host side of the two-wire bus: write and read of one register.
 Assumes the bench merges pulls into one open-drain SDA level.
*/
`timescale 1ns/1ps
module dscc_host_model (
    // Clock
    input wire logic mclk,
    // Bus wires
    input wire logic sda_line,
    output logic scl,
    output logic sda_pull
);
    // Bus idle
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // Quarter of a 320 ns SCL period
    task automatic q();
        repeat (2) @(negedge mclk);
    endtask : q
    // Start or repeated start, leaves SCL low
    task automatic start();
        sda_pull = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_pull = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask : start
    // Eight bits out, ninth released; SDA is held across the SCL high
    task automatic xfer(input logic [7:0] d, output logic [7:0] r,
                        output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_pull = (i > 0) ? ~d[i-1] : 1'b0;
            q();
            scl = 1'b1;
            q();
            if (i > 0) r[i-1] = sda_line;
            else ack = ~sda_line;
            q();
            scl = 1'b0;
            q();
        end
    endtask : xfer
    // Stop condition
    task automatic stop();
        sda_pull = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_pull = 1'b0;
        q();
    endtask : stop
    // One register write; ok only when every byte was acknowledged
    task automatic wr(input logic [6:0] dev, input logic [2:0] ofs,
                      input logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a;
        start();
        xfer({dev, 1'b0}, r, ok);
        xfer({5'h00, ofs}, r, a);
        ok = ok & a;
        xfer(d, r, a);
        ok = ok & a;
        stop();
    endtask : wr
    // One register read, closed with a not-acknowledge
    task automatic rd(input logic [6:0] dev, input logic [2:0] ofs,
                      output logic [7:0] d, output logic ok);
        logic [7:0] r;
        logic a;
        start();
        xfer({dev, 1'b0}, r, ok);
        xfer({5'h00, ofs}, r, a);
        start();
        xfer({dev, 1'b1}, r, a);
        ok = ok & a;
        xfer(8'hff, d, a);
        stop();
    endtask : rd
endmodule : dscc_host_model

// [verification/test_dual_source_charger_control.sv]
/*
 Bench of the dual source charger control: bank access, source choice,
 fault routing, watchdog and unattended timers with short counts.
 Assumes dscc_cfg.svh on the include path.
*/
`timescale 1ns/1ps
`include "dscc_cfg.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
    num_errors++; $display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module test_dual_source_charger_control;
    import dscc_pkg::*;
    localparam int T15 = 4000;
    localparam int T32 = 2000;
    logic mclk;
    logic reset_n;
    logic scl;
    logic pull;
    logic sda_out;
    logic sda_oe;
    logic boost_req;
    logic ok;
    logic [7:0] rdata;
    logic [12:0] float_mv;
    dscc_sense_type sense;
    dscc_ctrl_type ctrl;
    dscc_src_type src;
    int num_errors = 0;
    int samples_checked = 0;
    // SDA is low while either side pulls it
    wire sda_line = ~(sda_oe | pull);
    dscc_top #(.T15_CYC(36'(T15)), .T32_CYC(36'(T32))) dscc_top_i (
        .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .sense(sense),
        .boost_req(boost_req), .ctrl(ctrl), .float_mv(float_mv),
        .selected_charge_input(src));
    dscc_host_model dscc_host_model_i (.mclk(mclk), .sda_line(sda_line),
        .scl(scl), .sda_pull(pull));
    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    // Register access with acknowledge check
    task automatic rdx(input logic [6:0] dv, input logic [2:0] o,
                       input logic [7:0] m, input logic [7:0] e);
        dscc_host_model_i.rd(dv, o, rdata, ok);
        `CHK({ok, rdata & m}, {1'b1, e})
    endtask : rdx
    task automatic wrx(input logic [6:0] dv, input logic [2:0] o,
                       input logic [7:0] d);
        dscc_host_model_i.wr(dv, o, d, ok);
        `CHK(ok, 1'b1)
    endtask : wrx
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    initial begin
        #1200000;
        num_errors++;
        finish_test();
    end
    // Test sequence
    initial begin
        reset_n = 1'b0;
        boost_req = 1'b0;
        sense = '0;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        repeat (4) @(negedge mclk);
        rdx(`DSCC_ADDR_USB, `DSCC_OFS_LIMIT, 8'hff, `DSCC_RST_LIMIT);
        rdx(`DSCC_ADDR_WALL, `DSCC_OFS_FLOAT, 8'hff, `DSCC_RST_FLOAT);
        rdx(`DSCC_ADDR_WALL, 3'h3, 8'hff, 8'h00);
        dscc_host_model_i.wr(7'h55, 3'h2, 8'hfc, ok);
        `CHK(ok, 1'b0)
        sense.wall_valid = 1'b1;
        sense.usb_valid = 1'b1;
        sense.batt_weak = 1'b1;
        repeat (T15 + 10) @(negedge mclk);
        `CHK(ctrl.charge_on, 1'b0)
        sense.usb_valid = 1'b0;
        repeat (4) @(negedge mclk);
        sense.usb_valid = 1'b1;
        repeat (4) @(negedge mclk);
        rdx(`DSCC_ADDR_USB, `DSCC_OFS_LIMIT, 8'h04, 8'h04);
        rdx(`DSCC_ADDR_WALL, `DSCC_OFS_LIMIT, 8'h04, 8'h04);
        sense.wall_valid = 1'b0;
        sense.usb_valid = 1'b0;
        repeat (4) @(negedge mclk);
        sense.usb_valid = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK({src, ctrl.charge_on}, {DSCC_SRC_USB, 1'b1})
        sense.wall_valid = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK({src, ctrl.charge_on}, {DSCC_SRC_WALL, 1'b1})
        sense.wall_valid = 1'b0;
        wrx(`DSCC_ADDR_WALL, `DSCC_OFS_SPECIAL, 8'h03);
        sense.wall_valid = 1'b1;
        repeat (4) @(negedge mclk);
        `CHK({ctrl.charge_on, ctrl.block_path}, 2'b01)
        wrx(`DSCC_ADDR_WALL, `DSCC_OFS_SPECIAL, 8'h01);
        sense.fault_code = 3'h5;
        repeat (4) @(negedge mclk);
        `CHK(src, DSCC_SRC_WALL)
        sense.fault_event = 1'b1;
        @(negedge mclk);
        sense.fault_event = 1'b0;
        rdx(`DSCC_ADDR_WALL, `DSCC_OFS_STATUS, 8'h07, 8'h05);
        rdx(`DSCC_ADDR_USB, `DSCC_OFS_STATUS, 8'h07, 8'h00);
        wrx(`DSCC_ADDR_WALL, `DSCC_OFS_FLOAT, 8'hbc);
        `CHK({ctrl.float_voltage_code, float_mv}, {6'h2f, 13'h1158})
        wrx(`DSCC_ADDR_WALL, `DSCC_OFS_FLOAT, 8'hfc);
        wrx(`DSCC_ADDR_USB, `DSCC_OFS_FLOAT, 8'h40);
        `CHK(float_mv, 13'h1158)
        repeat (T32 + 50) @(negedge mclk);
        `CHK({ctrl.charge_on, float_mv}, {1'b1, 13'h0dd4})
        rdx(`DSCC_ADDR_WALL, `DSCC_OFS_STATUS, 8'h07, 8'h06);
        rdx(`DSCC_ADDR_USB, `DSCC_OFS_FLOAT, 8'hff, 8'h40);
        repeat (T15) @(negedge mclk);
        `CHK(ctrl.charge_on, 1'b0)
        rdx(`DSCC_ADDR_WALL, `DSCC_OFS_LIMIT, 8'h04, 8'h04);
        rdx(`DSCC_ADDR_USB, `DSCC_OFS_LIMIT, 8'h04, 8'h00);
        sense.wall_valid = 1'b0;
        repeat (4) @(negedge mclk);
        `CHK({src, float_mv}, {DSCC_SRC_USB, 13'h0eec})
        boost_req = 1'b1;
        sense.batt_short = 1'b1;
        @(negedge mclk);
        `CHK({ctrl.charge_on, ctrl.boost_on}, 2'b10)
        `CHK(ctrl.precharge, 1'b1)
        `CHK(ctrl.floor_loop_on, 1'b1)
        `CHK({ctrl.charge_current_code, sda_out}, 5'h00)
        `CHK(ctrl.termination_current_code, 3'h1)
        sense.term_reached = 1'b1;
        @(negedge mclk);
        `CHK(ctrl.charge_on, 1'b0)
        sense.term_reached = 1'b0;
        wrx(`DSCC_ADDR_USB, `DSCC_OFS_SPECIAL, 8'h03);
        `CHK({ctrl.block_path, ctrl.boost_on}, 2'b10)
        finish_test();
    end
endmodule : test_dual_source_charger_control
